// *** core/nsr_switch.sv ***
// nco-only dc injection, modulator switch and per-dac output ramps
// assumes nco carriers arrive from outside and the clock is the dac clock
//
// Behaviour
// (R1) nco-only: tone made by mixing dc samples, amplitude follows dc word
// (R2) each channel's dc word is programmable through paged amplitude regs
// (R3) main oscillator 0 uses channel 0 dc word, oscillator 1 channel 1
// (R4) nco-only keeps link samples out; per-path selector picks dc or link
// (R5) source selector may be changed while running
// (R6) host still selects a link mode so clock domains are set up
// (R7) host's chosen link mode must not bypass the nco
// (R8) four switch configurations from a two-bit field paged per dac
// (R9) configuration 2 sends I to dac0 and Q to dac1
// (R10) configuration 3: dac0 = I0 + I1, dac1 zero; depends on enables
// (R11) complex enable with configuration 3 takes samples from nco outputs
// (R12) configuration 3A: dac1 carries quadrature nco outputs of both paths
// (R13) complex, oscillator 1 off: dac0 real, dac1 quadrature of osc 0
// (R14) halving stage at switch input on by default, disable bit turns off
// (R15) each dac ramp mutes output when a protection trigger fires
// (R16) ramp is 32 steps over 2^(code+8) clocks, three-bit code
// (R17) ramp code held per dac ramp, selected by main dac page
// (R18) host restores output by writing ramp-up bit to 1 then 0
// (R19) mute-on-rotation: ramp down, rotate clocks, ramp back up
// (R20) soft-off rotation only when datapath rotation mode bit is set
// (R21) main dac paged controls act on dacs selected by page mask
// (R22) gain changes in equal steps, each held for equal clock counts
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
module nsr_switch import nsr_pkg::*; (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // sample inputs
  input  wire nsr_iq_t     link_iq_0,
  input  wire nsr_iq_t     link_iq_1,
  input  wire nsr_iq_t     carrier_0,
  input  wire nsr_iq_t     carrier_1,
  // system events
  input  wire logic        dac1_active,
  input  wire logic [1:0]  protect_trig,
  input  wire logic        sync_rotate,
  // outputs to dac cores
  output logic [15:0]      dac_sample_0,
  output logic [15:0]      dac_sample_1,
  output logic             clk_rotate
);

  // ==========================================================
  // helpers
  function automatic logic signed [15:0] sat16(
      input logic signed [17:0] v);
    if (v > 18'sd32767) sat16 = 16'sh7fff;
    else if (v < -18'sd32768) sat16 = 16'sh8000;
    else sat16 = v[15:0];
  endfunction : sat16

  // read picks the lowest selected page
  function automatic logic pick_page(input logic [1:0] mask);
    pick_page = !mask[0];
  endfunction : pick_page

  // ==========================================================
  // registers
  logic [7:0] page_reg;
  logic [7:0] rotmode_reg;
  logic [7:0] div2_reg;
  logic [7:0] dpcfg_reg    [2];
  logic [7:0] mainsrc_reg  [2];
  logic [7:0] rampcode_reg [2];
  logic [7:0] rampctl_reg  [2];
  logic [7:0] rampup_reg   [2];
  logic [7:0] chsrc_reg    [2];
  logic [7:0] dclo_reg     [2];
  logic [7:0] dchi_reg     [2];
  logic [1:0] dac_mask;
  logic [1:0] ch_mask;
  logic [1:0] up_pulse;

  assign dac_mask = page_reg[NSR_DAC_PAGE_LSB +: 2];
  assign ch_mask  = page_reg[NSR_CH_PAGE_LSB +: 2];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      page_reg    <= NSR_PAGE_RST;
      rotmode_reg <= NSR_ZERO_RST;
      div2_reg    <= NSR_ZERO_RST;
    end else if (reg_wr) begin
      if (reg_addr == NSR_PAGE_ADDR) page_reg <= reg_wdata;
      if (reg_addr == NSR_ROTMODE_ADDR) rotmode_reg <= reg_wdata;
      if (reg_addr == NSR_DIV2_ADDR) div2_reg <= reg_wdata;
    end
  end

  for (genvar k = 0; k < 2; k++) begin : g_regs
    logic wr_dac;
    logic wr_ch;
    assign wr_dac = reg_wr && dac_mask[k]; // R21
    assign wr_ch  = reg_wr && ch_mask[k]; // R2
    // ramp-up fires on the 1 -> 0 write of the control bit
    assign up_pulse[k] = wr_dac && reg_addr == NSR_RAMPUP_ADDR &&
                         rampup_reg[k][NSR_RAMPUP_BIT] &&
                         !reg_wdata[NSR_RAMPUP_BIT]; // R18

    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        dpcfg_reg[k]    <= NSR_DPCFG_RST;
        mainsrc_reg[k]  <= NSR_ZERO_RST;
        rampcode_reg[k] <= NSR_ZERO_RST;
        rampctl_reg[k]  <= NSR_ZERO_RST;
        rampup_reg[k]   <= NSR_ZERO_RST;
        chsrc_reg[k]    <= NSR_CHSRC_RST;
        dclo_reg[k]     <= NSR_ZERO_RST;
        dchi_reg[k]     <= NSR_ZERO_RST;
      end else begin
        if (wr_dac && reg_addr == NSR_DPCFG_ADDR) dpcfg_reg[k] <= reg_wdata;
        if (wr_dac && reg_addr == NSR_MAINSRC_ADDR)
          mainsrc_reg[k] <= reg_wdata;
        if (wr_dac && reg_addr == NSR_RAMPCODE_ADDR)
          rampcode_reg[k] <= reg_wdata; // R17
        if (wr_dac && reg_addr == NSR_RAMPCTL_ADDR)
          rampctl_reg[k] <= reg_wdata;
        if (wr_dac && reg_addr == NSR_RAMPUP_ADDR)
          rampup_reg[k] <= reg_wdata;
        if (wr_ch && reg_addr == NSR_CHSRC_ADDR) chsrc_reg[k] <= reg_wdata;
        if (wr_ch && reg_addr == NSR_DCLO_ADDR) dclo_reg[k] <= reg_wdata;
        if (wr_ch && reg_addr == NSR_DCHI_ADDR) dchi_reg[k] <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // source select and nco mixing, one per main path
  nsr_iq_t            path_iq [2];
  nsr_iq_t            nco_iq  [2];
  nsr_iq_t            half_by [2];
  nsr_iq_t            half_nc [2];
  logic               nco_en  [2];
  logic               use_dc  [2];
  logic               div2_off;
  logic signed [15:0] ramp_in [2];
  logic signed [15:0] ramp_out[2];
  logic [5:0]         gain    [2];
  logic [1:0]         rot_pulse;
  logic [1:0]         soft_rot;
  nsr_ramp_t          rstate  [2];
  logic               rot_dp;

  assign div2_off = div2_reg[NSR_DIV2_DIS_BIT];

  for (genvar k = 0; k < 2; k++) begin : g_path
    nsr_iq_t            link_in;
    nsr_iq_t            car;
    logic signed [31:0] p_ii;
    logic signed [31:0] p_qs;
    logic signed [31:0] p_is;
    logic signed [31:0] p_qc;
    logic signed [32:0] m_i;
    logic signed [32:0] m_q;
    assign link_in = (k == 0) ? link_iq_0 : link_iq_1;
    assign car     = (k == 0) ? carrier_0 : carrier_1;
    assign nco_en[k] = dpcfg_reg[k][NSR_NCO_EN_BIT];
    // link data is never passed while the dc word is chosen
    assign use_dc[k] = mainsrc_reg[k][NSR_MAINDC_BIT] ||
                       !chsrc_reg[k][NSR_CHLINK_BIT]; // R4 R5
    // main oscillator k shares channel k's dc word
    assign path_iq[k].i = use_dc[k] ?
                          $signed({dchi_reg[k], dclo_reg[k]}) :
                          link_in.i; // R1 R3
    assign path_iq[k].q = use_dc[k] ? 16'sh0000 : link_in.q;
    assign p_ii = path_iq[k].i * car.i;
    assign p_qs = path_iq[k].q * car.q;
    assign p_is = path_iq[k].i * car.q;
    assign p_qc = path_iq[k].q * car.i;
    assign m_i  = 33'(p_ii) - 33'(p_qs);
    assign m_q  = 33'(p_is) + 33'(p_qc);
    assign nco_iq[k].i = nco_en[k] ? sat16(m_i[32:15]) : path_iq[k].i; // R1
    assign nco_iq[k].q = nco_en[k] ? sat16(m_q[32:15]) : path_iq[k].q;
    // halving costs 6 dB but keeps the sums of config 3 in range
    assign half_by[k].i = div2_off ? path_iq[k].i : path_iq[k].i >>> 1;
    assign half_by[k].q = div2_off ? path_iq[k].q : path_iq[k].q >>> 1;
    assign half_nc[k].i = div2_off ? nco_iq[k].i : nco_iq[k].i >>> 1; // R14
    assign half_nc[k].q = div2_off ? nco_iq[k].q : nco_iq[k].q >>> 1;
  end

  // ==========================================================
  // modulator switch
  nsr_mode_t          mode;
  logic               cplx;
  logic               osc1_on;
  logic signed [15:0] sum_i;
  logic signed [15:0] sum_q;
  logic signed [15:0] sw0;
  logic signed [15:0] sw1;
  logic signed [15:0] sw0_reg;
  logic signed [15:0] sw1_reg;

  assign mode    = nsr_mode_t'(dpcfg_reg[0][NSR_MODE_LSB +: 2]); // R8
  assign cplx    = dpcfg_reg[0][NSR_CPLX_BIT];
  assign osc1_on = nco_en[1];
  assign sum_i   = sat16(18'(half_nc[0].i) +
                         18'(osc1_on ? half_nc[1].i : 16'sh0000)); // R10
  assign sum_q   = sat16(18'(half_nc[0].q) + 18'(half_nc[1].q)); // R12

  always_comb begin
    sw0 = half_nc[0].i;
    sw1 = half_nc[1].i;
    case (mode)
      NSR_CFG0: begin
        sw0 = half_nc[0].i;
        sw1 = half_nc[1].i;
      end
      NSR_CFG1: begin
        sw0 = half_by[0].i;
        sw1 = half_by[1].i;
      end
      NSR_CFG2: begin
        sw0 = half_by[0].i; // R9
        sw1 = half_by[0].q;
      end
      NSR_CFG3: begin
        if (cplx && osc1_on) begin
          sw0 = sum_i; // R11 R12
          sw1 = sum_q;
        end else if (cplx) begin
          sw0 = half_nc[0].i; // R13
          sw1 = half_nc[0].q;
        end else begin
          sw0 = sum_i; // R10
          sw1 = 16'sh0000;
        end
        if (!dac1_active) sw1 = 16'sh0000; // R10
      end
      default: begin
        sw0 = 16'sh0000;
        sw1 = 16'sh0000;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sw0_reg <= 16'sh0000;
      sw1_reg <= 16'sh0000;
    end else begin
      sw0_reg <= sw0;
      sw1_reg <= sw1;
    end
  end

  // ==========================================================
  // ramps and clock rotation
  assign rot_dp     = rotmode_reg[NSR_ROT_DP_BIT];
  assign ramp_in[0] = sw0_reg;
  assign ramp_in[1] = sw1_reg;

  for (genvar k = 0; k < 2; k++) begin : g_ramp
    assign soft_rot[k] = sync_rotate && rot_dp &&
                         rampctl_reg[k][NSR_SOFT_OFF_BIT]; // R19 R20
    nsr_ramp u_ramp (
      .core_clk       (core_clk),
      .sys_rst        (sys_rst),
      .step_code      (rampcode_reg[k][2:0]), // R16 R17
      .trigger        (protect_trig[k]), // R15
      .up_req         (up_pulse[k]), // R18
      .rot_req        (soft_rot[k]),
      .sample_in      (ramp_in[k]),
      .sample_out_reg (ramp_out[k]),
      .gain_reg       (gain[k]),
      .rot_pulse_reg  (rot_pulse[k]),
      .state_reg      (rstate[k])
    );
  end

  assign dac_sample_0 = ramp_out[0];
  assign dac_sample_1 = ramp_out[1];

  always_ff @(posedge core_clk) begin
    if (sys_rst) clk_rotate <= 1'b0;
    else clk_rotate <= (|rot_pulse) ||
                       (sync_rotate && rot_dp && soft_rot == 2'b00); // R20
  end

  // ==========================================================
  // register read, one cycle after the strobe
  logic       dsel;
  logic       csel;
  logic [7:0] rd_mux;
  assign dsel = pick_page(dac_mask);
  assign csel = pick_page(ch_mask);

  always_comb begin
    case (reg_addr)
      NSR_PAGE_ADDR:     rd_mux = page_reg;
      NSR_ROTMODE_ADDR:  rd_mux = rotmode_reg;
      NSR_DIV2_ADDR:     rd_mux = div2_reg;
      NSR_DPCFG_ADDR:    rd_mux = dpcfg_reg[dsel];
      NSR_MAINSRC_ADDR:  rd_mux = mainsrc_reg[dsel];
      NSR_RAMPCODE_ADDR: rd_mux = rampcode_reg[dsel];
      NSR_RAMPCTL_ADDR:  rd_mux = rampctl_reg[dsel];
      NSR_RAMPUP_ADDR:   rd_mux = rampup_reg[dsel];
      NSR_RAMPSTAT_ADDR: rd_mux = {2'h0, gain[dsel]};
      NSR_CHSRC_ADDR:    rd_mux = chsrc_reg[csel];
      NSR_DCLO_ADDR:     rd_mux = dclo_reg[csel];
      NSR_DCHI_ADDR:     rd_mux = dchi_reg[csel];
      default:           rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) reg_rdata <= 8'h00;
    else if (reg_rd) reg_rdata <= rd_mux;
    else reg_rdata <= 8'h00;
  end

  // ==========================================================
  // checks
  chk_cfg2_route: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode == NSR_CFG2) |=> sw1_reg == $past(half_by[0].q)) // R9
    else $error("config 2 did not route Q0 to dac1");
  chk_cfg3_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode == NSR_CFG3 && !cplx) |=> sw1_reg == 16'sh0000) // R10
    else $error("config 3 dac1 not zero");
  chk_cplx_3b: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode == NSR_CFG3 && cplx && !osc1_on && dac1_active) |=>
      sw1_reg == $past(half_nc[0].q)) // R13
    else $error("config 3B dac1 not osc0 quadrature");
  chk_dc_source: assert property (@(posedge core_clk) disable iff (sys_rst)
    use_dc[0] |-> path_iq[0].q == 16'sh0000 &&
      path_iq[0].i == $signed({dchi_reg[0], dclo_reg[0]})) // R4
    else $error("link data leaked in dc mode");
  chk_half_def: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!div2_off && mode == NSR_CFG1) |=>
      sw0_reg == ($past(path_iq[0].i) >>> 1)) // R14
    else $error("halving stage not applied");
  cov_cfg3a: cover property (@(posedge core_clk)
    mode == NSR_CFG3 && cplx && osc1_on);
  cov_up_req: cover property (@(posedge core_clk) up_pulse[0]);

endmodule : nsr_switch

// *** core/nsr_pkg.sv ***
// constants and types shared by the output switch and ramp blocks
// assumes byte-wide registers at 12-bit offsets and one dac-rate clock
package nsr_pkg;

  // ==========================================================
  // register offsets
  localparam logic [11:0] NSR_PAGE_ADDR     = 12'h008;
  localparam logic [11:0] NSR_ROTMODE_ADDR  = 12'h03b;
  localparam logic [11:0] NSR_DIV2_ADDR     = 12'h0ff;
  localparam logic [11:0] NSR_DPCFG_ADDR    = 12'h112;
  localparam logic [11:0] NSR_CHSRC_ADDR    = 12'h130;
  localparam logic [11:0] NSR_DCLO_ADDR     = 12'h148;
  localparam logic [11:0] NSR_DCHI_ADDR     = 12'h149;
  localparam logic [11:0] NSR_MAINSRC_ADDR  = 12'h1e6;
  localparam logic [11:0] NSR_RAMPCODE_ADDR = 12'h580;
  localparam logic [11:0] NSR_RAMPCTL_ADDR  = 12'h581;
  localparam logic [11:0] NSR_RAMPUP_ADDR   = 12'h582;
  localparam logic [11:0] NSR_RAMPSTAT_ADDR = 12'h583;

  // ==========================================================
  // field positions
  localparam int NSR_DAC_PAGE_LSB = 6;
  localparam int NSR_CH_PAGE_LSB  = 0;
  localparam int NSR_CPLX_BIT     = 6;
  localparam int NSR_MODE_LSB     = 4;
  localparam int NSR_NCO_EN_BIT   = 3;
  localparam int NSR_DIV2_DIS_BIT = 1;
  localparam int NSR_ROT_DP_BIT   = 1;
  localparam int NSR_SOFT_OFF_BIT = 2;
  localparam int NSR_RAMPUP_BIT   = 7;
  localparam int NSR_CHLINK_BIT   = 0;
  localparam int NSR_MAINDC_BIT   = 1;

  // ==========================================================
  // reset values
  localparam logic [7:0] NSR_PAGE_RST    = 8'hc3;
  localparam logic [7:0] NSR_DPCFG_RST   = 8'h30;
  localparam logic [7:0] NSR_CHSRC_RST   = 8'h01;
  localparam logic [7:0] NSR_ZERO_RST    = 8'h00;

  // ==========================================================
  // ramp timing: 32 steps over 2^(code+8) clocks
  localparam logic [5:0] NSR_RAMP_STEPS    = 6'd32;
  localparam logic [3:0] NSR_RAMP_SPAN_LOG = 4'h8;
  localparam logic [3:0] NSR_STEP_SHIFT    = NSR_RAMP_SPAN_LOG - 4'h5;

  typedef enum logic [1:0] {
    NSR_CFG0 = 2'h0,
    NSR_CFG1 = 2'h1,
    NSR_CFG2 = 2'h2,
    NSR_CFG3 = 2'h3
  } nsr_mode_t;

  typedef enum logic [3:0] {
    NSR_ON   = 4'h1,
    NSR_DOWN = 4'h2,
    NSR_OFF  = 4'h4,
    NSR_UP   = 4'h8
  } nsr_ramp_t;

  typedef struct packed {
    logic signed [15:0] i;
    logic signed [15:0] q;
  } nsr_iq_t;

endpackage : nsr_pkg

// *** core/nsr_ramp.sv ***
// gain ramp for one dac: mutes on trigger or rotation, restores on request
// assumes trigger is a level, up_req and rot_req are one-cycle pulses
`timescale 1ns/1ps
module nsr_ramp import nsr_pkg::*; (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  // control
  input  wire logic [2:0]         step_code,
  input  wire logic               trigger,
  input  wire logic               up_req,
  input  wire logic               rot_req,
  // data
  input  wire logic signed [15:0] sample_in,
  output logic signed [15:0]      sample_out_reg,
  output logic [5:0]              gain_reg,
  output logic                    rot_pulse_reg,
  output nsr_ramp_t               state_reg
);

  // ==========================================================
  // step timer
  logic [9:0]         cnt_reg;
  logic [9:0]         step_limit;
  logic               step_tick;
  logic               ramping;
  logic               rot_pend_reg;
  nsr_ramp_t          state_next;
  logic signed [22:0] prod;

  assign step_limit = 10'((11'd1 << ({1'b0, step_code} + NSR_STEP_SHIFT))
                          - 11'd1); // R16
  assign ramping    = (state_reg == NSR_DOWN) || (state_reg == NSR_UP);
  assign step_tick  = ramping && (cnt_reg == step_limit); // R22

  always_ff @(posedge core_clk) begin
    if (sys_rst || !ramping || step_tick) cnt_reg <= 10'h000;
    else cnt_reg <= cnt_reg + 10'h001;
  end

  // ==========================================================
  // ramp state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      NSR_ON:   if (trigger || rot_req) state_next = NSR_DOWN; // R15 R19
      NSR_DOWN: if (step_tick && gain_reg == 6'd1) state_next = NSR_OFF;
      NSR_OFF: begin
        if (rot_pend_reg || (up_req && !trigger)) state_next = NSR_UP;
      end
      NSR_UP: begin
        if (trigger) state_next = NSR_DOWN;
        else if (step_tick && gain_reg == NSR_RAMP_STEPS - 6'd1)
          state_next = NSR_ON;
      end
      default:  state_next = NSR_OFF;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg     <= NSR_ON;
      gain_reg      <= NSR_RAMP_STEPS;
      rot_pend_reg  <= 1'b0;
      rot_pulse_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      // a rotation that lands as the old one retires is kept
      rot_pend_reg  <= rot_req || (rot_pend_reg && state_reg != NSR_OFF);
      rot_pulse_reg <= rot_pend_reg && state_reg == NSR_OFF; // R19
      if (step_tick && state_reg == NSR_DOWN) gain_reg <= gain_reg - 6'd1;
      else if (step_tick && state_reg == NSR_UP)
        gain_reg <= gain_reg + 6'd1; // R16
    end
  end

  // ==========================================================
  // gain multiply, full scale is 32
  assign prod = sample_in * $signed({1'b0, gain_reg});

  always_ff @(posedge core_clk) begin
    if (sys_rst) sample_out_reg <= 16'sh0000;
    else sample_out_reg <= prod[20:5];
  end

  // ==========================================================
  // checks
  chk_trig_mutes: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_reg == NSR_ON && trigger) |=> state_reg == NSR_DOWN) // R15
    else $error("trigger did not start ramp down");
  chk_step_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    $changed(gain_reg) |-> $past(step_tick)) // R22
    else $error("gain moved off a step boundary");
  chk_down_mono: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_reg == NSR_DOWN && step_tick) |=>
      gain_reg == $past(gain_reg) - 6'd1) // R16
    else $error("ramp down step is not one unit");
  chk_off_silent: assert property ( // R15
    @(posedge core_clk) disable iff (sys_rst)
    state_reg == NSR_OFF |-> gain_reg == 6'd0 ##1 sample_out_reg == 16'sh0)
    else $error("muted output not zero");
  cov_ramp_down: cover property (@(posedge core_clk)
    state_reg == NSR_DOWN ##1 state_reg == NSR_OFF);
  cov_rotate: cover property (@(posedge core_clk) rot_pulse_reg);

endmodule : nsr_ramp

// *** verif/nsr_dac_model.sv ***
// analog dac core stand-in: counts rotations and notes whether dac0 was mute
// assumes samples and clk_rotate are registered on core_clk
`timescale 1ns/1ps
module nsr_dac_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // from the switch
  input  wire logic [15:0] dac_sample_0,
  input  wire logic        clk_rotate,
  // observations
  output int               rot_count,
  output logic             rot_muted
);
  // a rotation is soft only if the core already sees silence
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rot_count <= 0;
      rot_muted <= 1'b0;
    end else if (clk_rotate === 1'b1) begin
      rot_count <= rot_count + 1;
      rot_muted <= (dac_sample_0 === 16'h0000);
    end
  end
endmodule : nsr_dac_model

// *** verif/nsr_switch_bench.sv ***
// self-checking bench for the output switch and ramp block
// assumes the dac model beside it and a 40 MHz core clock
`timescale 1ns/1ps
module nsr_switch_bench import nsr_pkg::*; ;
  // ==========================================================
  // signals
  logic        core_clk     = 1'b0;
  logic        sys_rst      = 1'b1;
  logic [11:0] reg_addr     = 12'h000;
  logic [7:0]  reg_wdata    = 8'h00;
  logic        reg_wr       = 1'b0;
  logic        reg_rd       = 1'b0;
  logic [7:0]  reg_rdata;
  nsr_iq_t     link_iq_0    = '0;
  nsr_iq_t     link_iq_1    = '0;
  // cos = -1, sin = 0 makes the mixer an exact negation
  nsr_iq_t     carrier      = {16'h8000, 16'h0000};
  logic        dac1_active  = 1'b1;
  logic [1:0]  protect_trig = 2'b00;
  logic        sync_rotate  = 1'b0;
  logic [15:0] dac_sample_0;
  logic [15:0] dac_sample_1;
  logic [15:0] e0;
  logic [15:0] e1;
  logic        clk_rotate;
  logic        rot_muted;
  int          rot_count;
  int          num_errors   = 0;
  int          checks_done  = 0;
  int          n;
  integer      seed         = 32'hb5151eec;
  logic signed [15:0] d0;
  logic signed [15:0] d1;

  nsr_switch dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .link_iq_0(link_iq_0), .link_iq_1(link_iq_1),
    .carrier_0(carrier), .carrier_1(carrier), .dac1_active(dac1_active),
    .protect_trig(protect_trig), .sync_rotate(sync_rotate),
    .dac_sample_0(dac_sample_0), .dac_sample_1(dac_sample_1),
    .clk_rotate(clk_rotate)
  );
  nsr_dac_model model (
    .core_clk(core_clk), .sys_rst(sys_rst), .dac_sample_0(dac_sample_0),
    .clk_rotate(clk_rotate), .rot_count(rot_count), .rot_muted(rot_muted)
  );

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  // ==========================================================
  // helpers
  function automatic logic [15:0] hv(logic signed [15:0] a);
    return a >>> 1;
  endfunction : hv
  function automatic logic [15:0] ng(logic signed [15:0] a, b);
    return 16'(-(a + b));
  endfunction : ng

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (exp !== got) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(logic [11:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [11:0] a, logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check($sformatf("reg %h", a), {8'h00, exp}, {8'h00, reg_rdata});
  endtask : rd
  task automatic settle();
    repeat (4) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic draw();
    @(posedge core_clk);
    link_iq_0 <= {16'($random(seed) % 16384), 16'($random(seed) % 16384)};
    link_iq_1 <= {16'($random(seed) % 16384), 16'($random(seed) % 16384)};
    settle();
  endtask : draw
  task automatic pulse();
    @(posedge core_clk);
    sync_rotate <= 1'b1;
    @(posedge core_clk);
    sync_rotate <= 1'b0;
  endtask : pulse
  // counts cycles until dac0 reaches target; any step backwards is a fault
  task automatic ramp_wait(logic [15:0] target, int lo, int hi);
    logic [15:0] prev;
    int          mono;
    #1;
    n = 0;
    mono = 1;
    prev = dac_sample_0;
    while (dac_sample_0 !== target && n < 3000) begin
      @(posedge core_clk);
      #1;
      n++;
      if (target == 0 ? dac_sample_0 > prev : dac_sample_0 < prev) mono = 0;
      prev = dac_sample_0;
    end
    check("ramp time", 16'd1, 16'(n >= lo && n <= hi));
    check("ramp order", 16'd1, 16'(mono));
  endtask : ramp_wait

  initial begin
    #500000;
    num_errors++;
    print_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    d0 = 16'($random(seed) % 16384);
    d1 = 16'($random(seed) % 16384);
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(NSR_PAGE_ADDR, NSR_PAGE_RST);
    rd(NSR_DPCFG_ADDR, NSR_DPCFG_RST);
    rd(NSR_CHSRC_ADDR, NSR_CHSRC_RST);
    rd(12'h7ff, NSR_ZERO_RST);
    $display("test reset values done");
    wr(NSR_PAGE_ADDR, 8'hc1);
    wr(NSR_DCLO_ADDR, d0[7:0]);
    wr(NSR_DCHI_ADDR, d0[15:8]);
    wr(NSR_PAGE_ADDR, 8'hc2);
    wr(NSR_DCLO_ADDR, d1[7:0]);
    wr(NSR_DCHI_ADDR, d1[15:8]);
    wr(NSR_PAGE_ADDR, 8'hc3);
    wr(NSR_MAINSRC_ADDR, 8'h02);
    wr(NSR_DPCFG_ADDR, 8'h10);
    draw();
    check("dc0", hv(d0), dac_sample_0);
    check("dc1", hv(d1), dac_sample_1);
    wr(NSR_DIV2_ADDR, 8'h02);
    // host keeps the path set up and the nco in line; it is bypassed for the dc0, dc1, if and ramp checks
    wr(NSR_DPCFG_ADDR, 8'h08);
    draw();
    check("tone0", ng(d0, 0), dac_sample_0);
    check("tone1", ng(d1, 0), dac_sample_1);
    $display("test nco only done");
    wr(NSR_DIV2_ADDR, 8'h00);
    wr(NSR_MAINSRC_ADDR, 8'h00);
    wr(NSR_DPCFG_ADDR, 8'h20);
    draw();
    check("if i", hv(link_iq_0.i), dac_sample_0);
    check("if q", hv(link_iq_0.q), dac_sample_1);
    wr(NSR_DIV2_ADDR, 8'h02);
    for (int k = 0; k < 4; k++) begin
      wr(NSR_DPCFG_ADDR, k == 0 ? 8'h08 : (k == 1 ? 8'h38 : 8'h78));
      dac1_active <= (k != 3);
      draw();
      e0 = ng(link_iq_0.i, k == 0 ? 16'sh0 : link_iq_1.i);
      e1 = k == 0 ? ng(link_iq_1.i, 0) :
           (k == 2 ? ng(link_iq_0.q, link_iq_1.q) : 16'h0000);
      check("sw0", e0, dac_sample_0);
      check("sw1", e1, dac_sample_1);
    end
    dac1_active <= 1'b1;
    wr(NSR_PAGE_ADDR, 8'h83);
    wr(NSR_DPCFG_ADDR, 8'h70);
    rd(NSR_DPCFG_ADDR, 8'h70);
    wr(NSR_PAGE_ADDR, 8'h43);
    rd(NSR_DPCFG_ADDR, 8'h78);
    wr(NSR_PAGE_ADDR, 8'hc3);
    draw();
    check("cx0", ng(link_iq_0.i, 0), dac_sample_0);
    check("cx1", ng(link_iq_0.q, 0), dac_sample_1);
    $display("test switch done");
    link_iq_0 <= {16'h4000, 16'h0000};
    wr(NSR_DPCFG_ADDR, 8'h10);
    settle();
    @(posedge core_clk);
    protect_trig <= 2'b01;
    ramp_wait(16'h0000, 250, 266);
    rd(NSR_RAMPSTAT_ADDR, 8'h00);
    check("dac1 kept", link_iq_1.i, dac_sample_1);
    wr(NSR_RAMPCODE_ADDR, 8'h01);
    protect_trig <= 2'b00;
    wr(NSR_RAMPUP_ADDR, 8'h80);
    wr(NSR_RAMPUP_ADDR, 8'h00);
    ramp_wait(16'h4000, 505, 525);
    $display("test ramp done");
    wr(NSR_RAMPCTL_ADDR, 8'h04);
    wr(NSR_ROTMODE_ADDR, 8'h02);
    pulse();
    n = 0;
    while (rot_count != 1 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    check("rot muted", 16'd1, {15'h0000, rot_muted});
    ramp_wait(16'h4000, 495, 525);
    wr(NSR_ROTMODE_ADDR, 8'h00);
    pulse();
    repeat (50) @(posedge core_clk);
    #1;
    check("rot count", 16'd1, 16'(rot_count));
    check("no mute", 16'h4000, dac_sample_0);
    wr(NSR_RAMPCTL_ADDR, 8'h00);
    wr(NSR_ROTMODE_ADDR, 8'h02);
    pulse();
    repeat (4) @(posedge core_clk);
    #1;
    check("hard rot", 16'd2, 16'(rot_count));
    check("hard live", 16'd0, {15'h0000, rot_muted});
    $display("test rotation done");
    print_verdict();
  end
endmodule : nsr_switch_bench
